// ===== src/temp_sensor_config_event_ctrl.sv
// Configuration register and alert control of the temperature sensor
`timescale 1ns/10ps
`include "temp_cfg_map.svh"
module temp_sensor_config_event_ctrl
  import temp_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire host_req_t host_req,
  input wire temp_sample_t sample_in,
  input wire limit_set_t limits,
  output host_rsp_t host_rsp,
  output logic conversion_run,
  output logic critical_limit_locked,
  output logic window_limits_locked,
  output logic alert_pin_out,
  output logic alert_pin_oe
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    sensor_cfg_t cfg;
    logic [7:0] ptr;
    logic alert_latch;
    logic cond_prev;
    logic sample_seen;
    logic flags_new;
    logic asserted;
    logic conv_run;
    host_rsp_t rsp;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  logic lock_any;
  logic cfg_wr;
  logic cfg_rd;
  logic accept_sample;
  logic [7:0] hyst_steps;
  logic upper_above;
  logic lower_ok;
  logic crit_above;
  logic limit_cond;
  logic alert_drive;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // A field may change only when its guarding locks are clear
  function automatic logic guarded(input logic cur, input logic nxt,
                                   input logic locked);
    guarded = locked ? cur : nxt;
  endfunction : guarded

  function automatic logic [7:0] hyst_to_steps(input logic [1:0] sel);
    unique case (sel)
      2'b00: hyst_to_steps = `HYST_OFF_STEPS;
      2'b01: hyst_to_steps = `HYST_1P5_STEPS;
      2'b10: hyst_to_steps = `HYST_3P0_STEPS;
      2'b11: hyst_to_steps = `HYST_6P0_STEPS;
    endcase
  endfunction : hyst_to_steps

  function automatic logic [15:0] cfg_word(input sensor_cfg_t c,
                                           input logic status);
    cfg_word = `CFG_RESET;
    cfg_word[`CFG_HYST_HI:`CFG_HYST_LO] = c.hysteresis_select;
    cfg_word[`CFG_HALT_BIT] = c.conversion_halt;
    cfg_word[`CFG_CLOCK_BIT] = c.critical_limit_lock;
    cfg_word[`CFG_WLOCK_BIT] = c.alarm_window_lock;
    cfg_word[`CFG_ASTS_BIT] = status;
    cfg_word[`CFG_AEN_BIT] = c.alert_enable;
    cfg_word[`CFG_CONLY_BIT] = c.critical_only_select;
    cfg_word[`CFG_APOL_BIT] = c.alert_polarity;
    cfg_word[`CFG_AMODE_BIT] = c.alert_mode_select;
  endfunction : cfg_word

  // ****************************************************************
  // Decode
  // ****************************************************************
  always_comb begin
    lock_any = s_q.cfg.critical_limit_lock | s_q.cfg.alarm_window_lock;
    cfg_wr = host_req.data_wr && (s_q.ptr == `CFG_PTR_CONFIG);
    cfg_rd = host_req.data_rd && (s_q.ptr == `CFG_PTR_CONFIG);
    accept_sample = sample_in.valid && !s_q.cfg.conversion_halt;
    hyst_steps = hyst_to_steps(s_q.cfg.hysteresis_select);
  end

  // ****************************************************************
  // Trip points
  // ****************************************************************
  // All three share one hysteresis setting, so pin and status agree
  limit_tracker #(
    .INCLUSIVE(1'b0)
  ) upper_trk (
    .core_clk(core_clk),
    .rst(rst),
    .sample(accept_sample),
    .temp(sample_in.temp),
    .limit(limits.upper),
    .hyst_steps(hyst_steps),
    .above(upper_above)
  );

  // Lower trip is tracked as "inside window": set at or above the limit
  limit_tracker #(
    .INCLUSIVE(1'b1)
  ) lower_trk (
    .core_clk(core_clk),
    .rst(rst),
    .sample(accept_sample),
    .temp(sample_in.temp),
    .limit(limits.lower),
    .hyst_steps(hyst_steps),
    .above(lower_ok)
  );

  limit_tracker #(
    .INCLUSIVE(1'b0)
  ) crit_trk (
    .core_clk(core_clk),
    .rst(rst),
    .sample(accept_sample),
    .temp(sample_in.temp),
    .limit(limits.critical),
    .hyst_steps(hyst_steps),
    .above(crit_above)
  );

  always_comb begin
    if (s_q.cfg.critical_only_select) begin
      limit_cond = crit_above;
    end else begin
      limit_cond = crit_above | upper_above | ~lower_ok;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.rsp.valid = 1'b0;

    if (host_req.ptr_wr) begin
      s_d.ptr = host_req.ptr;
    end

    // Reserved bits and the status bit have no storage, so writes to
    // them vanish while still being taken by the bus
    if (cfg_wr) begin
      s_d.cfg.hysteresis_select = lock_any ? s_q.cfg.hysteresis_select
        : host_req.data[`CFG_HYST_HI:`CFG_HYST_LO];
      s_d.cfg.conversion_halt = host_req.data[`CFG_HALT_BIT] &
        (~lock_any | s_q.cfg.conversion_halt);
      s_d.cfg.critical_limit_lock = s_q.cfg.critical_limit_lock |
        host_req.data[`CFG_CLOCK_BIT];
      s_d.cfg.alarm_window_lock = s_q.cfg.alarm_window_lock |
        host_req.data[`CFG_WLOCK_BIT];
      s_d.cfg.alert_enable = guarded(s_q.cfg.alert_enable,
        host_req.data[`CFG_AEN_BIT], lock_any);
      s_d.cfg.critical_only_select = guarded(s_q.cfg.critical_only_select,
        host_req.data[`CFG_CONLY_BIT], s_q.cfg.alarm_window_lock);
      s_d.cfg.alert_polarity = guarded(s_q.cfg.alert_polarity,
        host_req.data[`CFG_APOL_BIT], lock_any);
      s_d.cfg.alert_mode_select = guarded(s_q.cfg.alert_mode_select,
        host_req.data[`CFG_AMODE_BIT], lock_any);
      if (host_req.data[`CFG_ACLR_BIT] && s_q.cfg.alert_mode_select) begin
        s_d.alert_latch = 1'b0;
      end
    end

    // Trip flags settle one edge after a sample, so the rise of the
    // condition is judged then, not against the stale flags; an event
    // in the same cycle as a clear keeps the latch set
    s_d.flags_new = accept_sample;
    if (accept_sample) begin
      s_d.sample_seen = 1'b1;
    end
    // Only interrupt mode latches; a latch left set is kept through comparator mode and seen again on return
    if (s_q.flags_new) begin
      s_d.cond_prev = limit_cond;
      if (limit_cond && !s_q.cond_prev && s_q.cfg.alert_enable &&
          s_q.cfg.alert_mode_select && !s_q.cfg.conversion_halt) begin
        s_d.alert_latch = 1'b1;
      end
    end

    // Entering halt forgets the last sample so the alert waits for a
    // new one, but a pending interrupt survives the halt
    if (s_q.cfg.conversion_halt) begin
      s_d.sample_seen = 1'b0;
      s_d.cond_prev = 1'b0;
    end

    if (!s_q.cfg.conversion_halt && s_q.cfg.alert_enable &&
        s_q.sample_seen) begin
      s_d.asserted = s_q.cfg.alert_mode_select ? s_q.alert_latch
                                               : limit_cond;
    end else begin
      s_d.asserted = 1'b0;
    end

    s_d.conv_run = !s_d.cfg.conversion_halt;

    // Reads are served in halt too; only the converter and the alert stop
    if (host_req.data_rd) begin
      s_d.rsp.valid = 1'b1;
      s_d.rsp.data = cfg_rd ? cfg_word(s_q.cfg, s_q.asserted)
                            : `CFG_RESET;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Pin and outputs
  // ****************************************************************
  always_comb begin
    alert_drive = !s_q.cfg.conversion_halt && s_q.cfg.alert_enable;
  end

  alert_pin_drive pin_drv (
    .core_clk(core_clk),
    .rst(rst),
    .drive(alert_drive),
    .asserted(s_q.asserted),
    .polarity(s_q.cfg.alert_polarity),
    .pin_out(alert_pin_out),
    .pin_oe(alert_pin_oe)
  );

  assign host_rsp = s_q.rsp;
  assign conversion_run = s_q.conv_run;
  assign critical_limit_locked = s_q.cfg.critical_limit_lock;
  assign window_limits_locked = s_q.cfg.alarm_window_lock;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  reserved_read_zero_a: assert property (
    host_rsp.valid |-> host_rsp.data[15:11] == 5'h00)
    else $error("reserved bits read nonzero");

  hyst_locked_a: assert property (
    lock_any && cfg_wr |=> $stable(s_q.cfg.hysteresis_select))
    else $error("hysteresis changed while locked");

  halt_refused_a: assert property (
    lock_any && !s_q.cfg.conversion_halt |=> !s_q.cfg.conversion_halt)
    else $error("halt set while locked");

  halt_pin_free_a: assert property (
    s_q.cfg.conversion_halt [*2] |-> !alert_pin_oe && !s_q.asserted)
    else $error("alert pin driven while halted");

  crit_lock_sticky_a: assert property (
    s_q.cfg.critical_limit_lock |=> s_q.cfg.critical_limit_lock)
    else $error("critical lock cleared by a write");

  window_lock_sticky_a: assert property (
    s_q.cfg.alarm_window_lock |=> s_q.cfg.alarm_window_lock)
    else $error("window lock cleared by a write");

  clear_reads_zero_a: assert property (
    host_rsp.valid |-> !host_rsp.data[`CFG_ACLR_BIT])
    else $error("alert clear bit read back as one");

  status_match_a: assert property (
    cfg_rd |=> host_rsp.data[`CFG_ASTS_BIT] == $past(s_q.asserted))
    else $error("alert status differs from alert state");

  enable_gate_a: assert property (
    !s_q.cfg.alert_enable |=> !s_q.asserted && !alert_pin_oe)
    else $error("alert raised while disabled");

  mode_locked_a: assert property (
    lock_any && cfg_wr |=> $stable(s_q.cfg.alert_mode_select) &&
      $stable(s_q.cfg.alert_polarity) && $stable(s_q.cfg.alert_enable))
    else $error("alert controls changed while locked");

  crit_only_lock_a: assert property (
    s_q.cfg.alarm_window_lock && cfg_wr
      |=> $stable(s_q.cfg.critical_only_select))
    else $error("critical-only select changed while window locked");

  interrupt_hold_a: assert property (
    s_q.alert_latch && !(cfg_wr && host_req.data[`CFG_ACLR_BIT] &&
      s_q.cfg.alert_mode_select) |=> s_q.alert_latch)
    else $error("interrupt alert dropped without a clear");

  comparator_follow_a: assert property (
    !s_q.cfg.alert_mode_select && s_q.cfg.alert_enable &&
    !s_q.cfg.conversion_halt && s_q.sample_seen
      |=> s_q.asserted == $past(limit_cond))
    else $error("comparator alert does not follow condition");

  resume_wait_a: assert property (
    $fell(s_q.cfg.conversion_halt) && !accept_sample |=> !s_q.asserted)
    else $error("alert raised before a fresh sample");

endmodule : temp_sensor_config_event_ctrl

// ===== src/temp_cfg_map.svh
// Register offsets, field positions, reset values and hysteresis counts
`ifndef TEMP_CFG_MAP_SVH
`define TEMP_CFG_MAP_SVH

// ****************************************************************
// Pointer values
// ****************************************************************
`define CFG_PTR_WIDTH 8
`define CFG_PTR_RESET 8'h00
`define CFG_PTR_CONFIG 8'h01

// ****************************************************************
// Configuration word field positions
// ****************************************************************
`define CFG_RSVD_HI 15
`define CFG_RSVD_LO 11
`define CFG_HYST_HI 10
`define CFG_HYST_LO 9
`define CFG_HALT_BIT 8
`define CFG_CLOCK_BIT 7
`define CFG_WLOCK_BIT 6
`define CFG_ACLR_BIT 5
`define CFG_ASTS_BIT 4
`define CFG_AEN_BIT 3
`define CFG_CONLY_BIT 2
`define CFG_APOL_BIT 1
`define CFG_AMODE_BIT 0
`define CFG_RESET 16'h0000

// ****************************************************************
// Hysteresis in temperature steps of 0.0625 degrees
// ****************************************************************
`define HYST_OFF_STEPS 8'h00
`define HYST_1P5_STEPS 8'h18
`define HYST_3P0_STEPS 8'h30
`define HYST_6P0_STEPS 8'h60

`endif

// ===== src/temp_cfg_pkg.sv
// Types shared by the configuration and alert control block
package temp_cfg_pkg;

  typedef struct packed {
    logic [1:0] hysteresis_select;
    logic conversion_halt;
    logic critical_limit_lock;
    logic alarm_window_lock;
    logic alert_enable;
    logic critical_only_select;
    logic alert_polarity;
    logic alert_mode_select;
  } sensor_cfg_t;

  // One access from the serial bus protocol engine
  typedef struct packed {
    logic ptr_wr;
    logic [7:0] ptr;
    logic data_wr;
    logic [15:0] data;
    logic data_rd;
  } host_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } host_rsp_t;

  typedef struct packed {
    logic valid;
    logic [12:0] temp;
  } temp_sample_t;

  typedef struct packed {
    logic [12:0] upper;
    logic [12:0] lower;
    logic [12:0] critical;
  } limit_set_t;

endpackage : temp_cfg_pkg

// ===== src/limit_tracker.sv
// One temperature trip point with hysteresis on falling temperature
`timescale 1ns/10ps
module limit_tracker #(
  parameter bit INCLUSIVE = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sample,
  input wire logic [12:0] temp,
  input wire logic [12:0] limit,
  input wire logic [7:0] hyst_steps,
  output logic above
);

  typedef struct packed {
    logic above;
  } trk_state_t;

  trk_state_t s_q;
  trk_state_t s_d;
  logic [13:0] release_pt;
  logic rise_hit;
  logic fall_hit;

  // Rising crosses the bare limit, falling must pass limit minus hysteresis
  always_comb begin
    release_pt = {limit[12], limit} - {6'h00, hyst_steps};
    rise_hit = INCLUSIVE ? ($signed(temp) >= $signed(limit))
                         : ($signed(temp) > $signed(limit));
    fall_hit = $signed({temp[12], temp}) < $signed(release_pt);
    s_d = s_q;
    if (sample) begin
      if (rise_hit) begin
        s_d.above = 1'b1;
      end else if (fall_hit) begin
        s_d.above = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign above = s_q.above;

  hyst_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    s_q.above && sample && !rise_hit && !fall_hit |=> s_q.above)
    else $error("trip flag dropped inside the hysteresis band");

endmodule : limit_tracker

// ===== src/alert_pin_drive.sv
// Alert pin driver with selectable polarity, driving both levels whenever enabled
`timescale 1ns/10ps
module alert_pin_drive (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic drive,
  input wire logic asserted,
  input wire logic polarity,
  output logic pin_out,
  output logic pin_oe
);

  typedef struct packed {
    logic out;
    logic oe;
  } pin_state_t;

  pin_state_t s_q;
  pin_state_t s_d;

  // Pin level is the alert level for active high, its inverse for low
  always_comb begin
    s_d.oe = drive;
    s_d.out = drive & (polarity ? asserted : ~asserted);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_out = s_q.out;
  assign pin_oe = s_q.oe;

  pin_level_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(drive) |-> pin_out == ($past(asserted) == $past(polarity)))
    else $error("alert pin level disagrees with polarity");

endmodule : alert_pin_drive

// ===== verification/sensor_front_model.sv
// Temperature front end and pulled-up alert wire facing the block
`timescale 1ns/10ps
module sensor_front_model
  import temp_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic conversion_run,
  input wire logic take,
  input wire logic [12:0] temp_level,
  input wire logic pin_out,
  input wire logic pin_oe,
  output temp_sample_t sample_out,
  output logic pin_level
);
  // ****************************************************************
  // Conversion
  // ****************************************************************
  // A requested conversion is lost while the converter is held off
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sample_out <= '0;
    end else begin
      sample_out.valid <= take && conversion_run;
      sample_out.temp <= temp_level;
    end
  end

  // ****************************************************************
  // Alert wire
  // ****************************************************************
  // Pull-up wins whenever the device lets go of the pin
  assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule : sensor_front_model

// ===== verification/temp_sensor_config_event_ctrl_test.sv
// Self-checking bench for the configuration register and alert control
`timescale 1ns/10ps
module temp_sensor_config_event_ctrl_test
  import temp_cfg_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst;
  logic take;
  logic [12:0] temp_level;
  host_req_t req;
  host_rsp_t rsp;
  limit_set_t lim;
  temp_sample_t smp_bus;
  logic conversion_run;
  logic crit_locked;
  logic win_locked;
  logic pin_out;
  logic pin_oe;
  logic pin_level;
  int err_count = 0;
  int checked = 0;

  always #10 core_clk = ~core_clk;

  temp_sensor_config_event_ctrl i_dut (
    .core_clk(core_clk),
    .rst(rst),
    .host_req(req),
    .sample_in(smp_bus),
    .limits(lim),
    .host_rsp(rsp),
    .conversion_run(conversion_run),
    .critical_limit_locked(crit_locked),
    .window_limits_locked(win_locked),
    .alert_pin_out(pin_out),
    .alert_pin_oe(pin_oe)
  );

  sensor_front_model i_front (
    .core_clk(core_clk),
    .rst(rst),
    .conversion_run(conversion_run),
    .take(take),
    .temp_level(temp_level),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .sample_out(smp_bus),
    .pin_level(pin_level)
  );

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    req.ptr_wr = 1'b1;
    req.ptr = p;
    tick(1);
    req.ptr_wr = 1'b0;
    req.data_wr = 1'b1;
    req.data = d;
    tick(1);
    req.data_wr = 1'b0;
  endtask : wr

  // Answer arrives a fixed cycle later; a short bounded poll absorbs it
  task automatic rd(input logic [7:0] p, input logic [15:0] exp);
    int n;
    req.ptr_wr = 1'b1;
    req.ptr = p;
    tick(1);
    req.ptr_wr = 1'b0;
    req.data_rd = 1'b1;
    tick(1);
    req.data_rd = 1'b0;
    n = 0;
    while (rsp.valid !== 1'b1 && n < 3) begin
      tick(1);
      n++;
    end
    chk("read valid", 16'h0001, {15'h0000, rsp.valid});
    chk("read data", exp, rsp.data);
  endtask : rd

  // Alert reaches the pin three edges after the sample lands, four in interrupt mode
  task automatic smp(input logic [12:0] t);
    temp_level = t;
    take = 1'b1;
    tick(1);
    take = 1'b0;
    tick(6);
  endtask : smp

  task automatic give_verdict;
    $display("Checks %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial begin
    #(20 * 3000);
    err_count++;
    give_verdict();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    rst = 1'b1;
    req = '0;
    take = 1'b0;
    temp_level = 13'h0050;
    lim.upper = 13'h0100;
    lim.lower = 13'h0000;
    lim.critical = 13'h0200;
    tick(2);
    rst = 1'b0;
    tick(2);
    rd(8'h01, 16'h0000);
    chk("run", 16'h0001, {15'h0000, conversion_run});
    wr(8'h01, 16'hF82F);
    rd(8'h01, 16'h000F);
    wr(8'h01, 16'h0208);
    rd(8'h01, 16'h0208);
    smp(13'h0110);
    rd(8'h01, 16'h0218);
    chk("pin low", 16'h0000, {15'h0000, pin_level});
    smp(13'h00F0);
    rd(8'h01, 16'h0218);
    smp(13'h00E0);
    rd(8'h01, 16'h0208);
    chk("pin free", 16'h0001, {15'h0000, pin_level});
    wr(8'h01, 16'h020C);
    smp(13'h0110);
    rd(8'h01, 16'h020C);
    smp(13'h0210);
    rd(8'h01, 16'h021C);
    smp(13'h0050);
    wr(8'h01, 16'h000B);
    smp(13'h0110);
    rd(8'h01, 16'h001B);
    chk("pin high", 16'h0001, {15'h0000, pin_level});
    smp(13'h0050);
    rd(8'h01, 16'h001B);
    wr(8'h01, 16'h002B);
    rd(8'h01, 16'h000B);
    chk("pin idle", 16'h0000, {15'h0000, pin_level});
    smp(13'h0110);
    rd(8'h01, 16'h001B);
    wr(8'h01, 16'h0108);
    tick(2);
    chk("halt run", 16'h0000, {15'h0000, conversion_run});
    chk("halt oe", 16'h0000, {15'h0000, pin_oe});
    smp(13'h0110);
    rd(8'h01, 16'h0108);
    wr(8'h01, 16'h0008);
    tick(3);
    rd(8'h01, 16'h0008);
    smp(13'h0110);
    rd(8'h01, 16'h0018);
    wr(8'h01, 16'h0028);
    rd(8'h01, 16'h0018);
    smp(13'h0050);
    wr(8'h01, 16'h0108);
    wr(8'h01, 16'h01C8);
    rd(8'h01, 16'h01C8);
    chk("locks", 16'h0003, {14'h0000, crit_locked, win_locked});
    wr(8'h01, 16'h0000);
    rd(8'h01, 16'h00C8);
    wr(8'h01, 16'h0707);
    rd(8'h01, 16'h00C8);
    wr(8'h02, 16'h0000);
    rd(8'h02, 16'h0000);
    rd(8'h01, 16'h00C8);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(2);
    rd(8'h01, 16'h0000);
    chk("unlocked", 16'h0000, {14'h0000, crit_locked, win_locked});
    give_verdict();
  end
endmodule : temp_sensor_config_event_ctrl_test
